// *** scs_pkg.sv ***
// package of constants and types for the scanner channel select block
package scs_pkg;

    // ---------------------------------------------------------------
    // dimensions
    // ---------------------------------------------------------------
    localparam int unsigned NUM_CHANNELS  = 256;
    localparam int unsigned CH_W          = 8;
    localparam int unsigned DATA_W        = 32;
    localparam int unsigned KIND_W        = 2;

    // ---------------------------------------------------------------
    // register byte offsets
    // ---------------------------------------------------------------
    localparam logic [11:0] OFS_CTRL      = 12'h000;
    localparam logic [11:0] OFS_CHAN      = 12'h004;
    localparam logic [11:0] OFS_CMD       = 12'h008;
    localparam logic [11:0] OFS_DATA      = 12'h00C;
    localparam logic [11:0] OFS_STATUS    = 12'h010;
    localparam logic [11:0] OFS_IRQ_STAT  = 12'h014;
    localparam logic [11:0] OFS_IRQ_EN    = 12'h018;
    localparam logic [11:0] OFS_IRQ_CLR   = 12'h01C;
    localparam logic [11:0] OFS_RD_ADDR   = 12'h020;
    localparam logic [11:0] OFS_RD_DATA   = 12'h024;

    // ---------------------------------------------------------------
    // control register fields
    // ---------------------------------------------------------------
    localparam int unsigned CTRL_MULTI    = 0;
    localparam int unsigned CTRL_EXTERNAL_TRIGGER_IN = 1;
    localparam int unsigned CTRL_REF_COMMON = 2;

    // command register fields: [1:0] kind, [2] store, [3] analog done,
    // [4] measure done, [5] up one, [6] up ten, [7] down one, [8] down ten
    localparam int unsigned CMD_STORE     = 2;
    localparam int unsigned CMD_ANA_DONE  = 3;
    localparam int unsigned CMD_MEAS_DONE = 4;
    localparam int unsigned CMD_UP1       = 5;
    localparam int unsigned CMD_UP10      = 6;
    localparam int unsigned CMD_DN1       = 7;
    localparam int unsigned CMD_DN10      = 8;

    // interrupt bits
    localparam int unsigned IRQ_TRIG      = 0;
    localparam int unsigned IRQ_CHLOAD    = 1;
    localparam int unsigned IRQ_W         = 2;

    // reset values
    localparam logic [2:0]      CTRL_RST  = 3'h0;
    localparam logic [CH_W-1:0] CHAN_RST  = 8'h00;

    // correction data kinds
    typedef enum logic [1:0] {
        SCS_OPEN  = 2'h0,
        SCS_SHORT = 2'h1,
        SCS_LOAD  = 2'h2,
        SCS_REF   = 2'h3
    } scs_kind_t;

endpackage

// *** scs_store_if.sv ***
// interface carrying correction store traffic between select logic and memory
`timescale 1ns/100ps
interface scs_store_if;
    import scs_pkg::*;
    logic                wr_en;
    logic                wr_all;
    logic [1:0]          wr_kind;
    logic [CH_W-1:0]     wr_chan;
    logic [DATA_W-1:0]   wr_data;
    logic [CH_W-1:0]     rd_chan;
    logic [1:0]          rd_kind;
    logic [DATA_W-1:0]   rd_data;
    modport ctrl (output wr_en, wr_all, wr_kind, wr_chan, wr_data, rd_chan, rd_kind,
                  input rd_data);
    modport mem  (input wr_en, wr_all, wr_kind, wr_chan, wr_data, rd_chan, rd_kind,
                  output rd_data);
endinterface

// *** scs_corr_mem.sv ***
// per-channel correction storage, no reset so contents survive resets
`timescale 1ns/100ps
module scs_corr_mem
    import scs_pkg::*;
(
    input  wire logic pclk,
    input  wire logic ce,
    scs_store_if.mem  st
);
    // ---------------------------------------------------------------
    // storage array
    // ---------------------------------------------------------------
    // one word per channel and kind; left without reset or clear path
    logic [DATA_W-1:0] mem_q [NUM_CHANNELS*4];
    logic [DATA_W-1:0] rd_q;

    // write one channel, or every channel for a common reference
    always_ff @(posedge pclk) begin
        if (ce && st.wr_en) begin
            for (int i = 0; i < NUM_CHANNELS; i++) begin
                if (st.wr_all || (st.wr_chan == CH_W'(i))) begin
                    mem_q[{CH_W'(i), st.wr_kind}] <= st.wr_data;
                end
            end
        end
        if (ce) begin
            rd_q <= mem_q[{st.rd_chan, st.rd_kind}];
        end
    end

    assign st.rd_data = rd_q;
endmodule

// *** scs_channel_select.sv ***
// scanner channel select with apb registers and correction storage
//
// The register offsets and register access over APB were chosen for this implementation.
`timescale 1ns/100ps
// Overview of operation
// - 256 correction sets, selected channel applied
// - multi off ignores channel lines, qualifier
// - multi off holds both done outputs low
// - external trigger accepted in external mode
// - channel lines inverted, low means one
// - line seven is msb, zero lsb
// - trigger with qualifier low loads channel
// - panel choice immediate, scanner on trigger
// - correction data kept, never initialized
// - reference per channel or to all
// - correction results stored to selected channel
// - panel keys step channel by 1 or 10
// - slash signals active low
// - analog done drives output low
// - measurement done drives output low
// - measurement starts on trigger rising edge
module scs_channel_select
    import scs_pkg::*;
(
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              ce,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [11:0]       paddr,
    input  wire logic [31:0]       pwdata,
    output logic [31:0]            prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic [CH_W-1:0]   channel_number_lines_n,
    input  wire logic              channel_select_qualifier_n,
    input  wire logic              external_trigger_in,
    output logic                   analog_done_out_n,
    output logic                   measurement_done_out_n,
    output logic                   measure_start,
    output logic [CH_W-1:0]        active_channel,
    output logic                   irq
);
    import scs_pkg::*;

    // ---------------------------------------------------------------
    // elaboration checks
    // ---------------------------------------------------------------
    // every channel code on the lines must have its own storage slot
    if (NUM_CHANNELS != (1 << CH_W)) begin : g_chan_count_bad
        $error("channel count does not match channel line width");
    end
    // the store interface carries the kind as a two-bit field
    if (KIND_W != 2) begin : g_kind_width_bad
        $error("correction kind width must be two bits");
    end
    // interrupt read-back pads to a full word for two bits only
    if (IRQ_W != 2) begin : g_irq_width_bad
        $error("interrupt field width must be two bits");
    end

    // ---------------------------------------------------------------
    // pin synchronisers
    // ---------------------------------------------------------------
    logic [CH_W+1:0] sy1_q, sy2_q, sy1_d, sy2_d;
    logic            trig_prev_q, trig_prev_d;

    // two flops for every pin, first stage read only by the second
    always_comb begin
        sy1_d = {external_trigger_in, channel_select_qualifier_n, channel_number_lines_n};
        sy2_d = sy1_q;
        trig_prev_d = sy2_q[CH_W+1];
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sy1_q       <= '0;
            sy2_q       <= '0;
            trig_prev_q <= 1'b0;
        end else if (ce) begin
            sy1_q       <= sy1_d;
            sy2_q       <= sy2_d;
            trig_prev_q <= trig_prev_d;
        end
    end

    logic [CH_W-1:0] lines_n;
    logic            qual_n;
    logic            trig_s;
    assign lines_n = sy2_q[CH_W-1:0];
    assign qual_n  = sy2_q[CH_W];
    assign trig_s  = sy2_q[CH_W+1];

    // ---------------------------------------------------------------
    // apb decode
    // ---------------------------------------------------------------
    logic wr_acc, rd_acc;
    assign pready  = 1'b1;                              // zero wait states
    assign wr_acc  = psel && penable && pwrite && ce;
    assign rd_acc  = psel && penable && !pwrite;

    logic known;
    always_comb begin
        case (paddr)
            OFS_CTRL, OFS_CHAN, OFS_CMD, OFS_DATA, OFS_STATUS,
            OFS_IRQ_STAT, OFS_IRQ_EN, OFS_IRQ_CLR, OFS_RD_ADDR, OFS_RD_DATA: known = 1'b1;
            default: known = 1'b0;
        endcase
    end
    assign pslverr = psel && penable && !known;         // unmapped answers error

    // ---------------------------------------------------------------
    // control state
    // ---------------------------------------------------------------
    logic [2:0]        ctrl_q, ctrl_d;
    logic [CH_W-1:0]   chan_q, chan_d;
    logic [DATA_W-1:0] data_q, data_d;
    logic              ana_q, ana_d;
    logic              meas_q, meas_d;
    logic              start_q, start_d;
    logic [IRQ_W-1:0]  ist_q, ist_d, ien_q, ien_d;
    logic [CH_W+1:0]   rda_q, rda_d;
    logic [31:0]       rdat_d;

    logic multi_on, ext_mode, trig_rise, ch_load;
    assign multi_on  = ctrl_q[CTRL_MULTI];
    assign ext_mode  = ctrl_q[CTRL_EXTERNAL_TRIGGER_IN];
    // rising edge starts measurement in external mode, multi state aside
    assign trig_rise = ext_mode && trig_s && !trig_prev_q;
    // scanner value taken only on a trigger with qualifier low
    assign ch_load   = trig_rise && multi_on && !qual_n;

    logic [CH_W-1:0] scan_chan;
    assign scan_chan = ~lines_n;

    logic [31:0] cmd;
    assign cmd = pwdata;

    // next-state logic for channel, control and outputs
    always_comb begin
        ctrl_d  = ctrl_q;
        chan_d  = chan_q;
        data_d  = data_q;
        ana_d   = ana_q;
        meas_d  = meas_q;
        start_d = trig_rise;
        ist_d   = ist_q;
        ien_d   = ien_q;
        rda_d   = rda_q;
        if (wr_acc && paddr == OFS_CTRL) begin
            ctrl_d = pwdata[2:0];
        end
        if (wr_acc && paddr == OFS_CHAN) begin
            chan_d = pwdata[CH_W-1:0];
        end
        if (wr_acc && paddr == OFS_DATA) begin
            data_d = pwdata;
        end
        if (wr_acc && paddr == OFS_IRQ_EN) begin
            ien_d = pwdata[IRQ_W-1:0];
        end
        if (wr_acc && paddr == OFS_RD_ADDR) begin
            rda_d = pwdata[CH_W+1:0];
        end
        if (wr_acc && paddr == OFS_CMD) begin
            // wrap-around at the ends of the channel range
            if (cmd[CMD_UP1])  chan_d = chan_q + CH_W'(1);
            if (cmd[CMD_UP10]) chan_d = chan_q + CH_W'(10);
            if (cmd[CMD_DN1])  chan_d = chan_q - CH_W'(1);
            if (cmd[CMD_DN10]) chan_d = chan_q - CH_W'(10);
            if (cmd[CMD_ANA_DONE])  ana_d  = 1'b1;
            if (cmd[CMD_MEAS_DONE]) meas_d = 1'b1;
        end
        // a new trigger clears the done flags for the next cycle
        if (trig_rise) begin
            ana_d  = 1'b0;
            meas_d = 1'b0;
        end
        // scanner load overrides a panel change in the same cycle
        if (ch_load) begin
            chan_d = scan_chan;
        end
        if (wr_acc && paddr == OFS_IRQ_CLR) begin
            ist_d = ist_q & ~pwdata[IRQ_W-1:0];
        end
        // set wins over a clear in the same cycle
        if (trig_rise) ist_d[IRQ_TRIG]   = 1'b1;
        if (ch_load)   ist_d[IRQ_CHLOAD] = 1'b1;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q  <= CTRL_RST;
            chan_q  <= CHAN_RST;
            data_q  <= '0;
            ana_q   <= 1'b0;
            meas_q  <= 1'b0;
            start_q <= 1'b0;
            ist_q   <= '0;
            ien_q   <= '0;
            rda_q   <= '0;
        end else if (ce) begin
            ctrl_q  <= ctrl_d;
            chan_q  <= chan_d;
            data_q  <= data_d;
            ana_q   <= ana_d;
            meas_q  <= meas_d;
            start_q <= start_d;
            ist_q   <= ist_d;
            ien_q   <= ien_d;
            rda_q   <= rda_d;
        end
    end

    // ---------------------------------------------------------------
    // outputs
    // ---------------------------------------------------------------
    // done outputs pulled low while multi is off regardless of flags
    logic ana_n_q, meas_n_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ana_n_q  <= 1'b0;
            meas_n_q <= 1'b0;
        end else if (ce) begin
            ana_n_q  <= multi_on ? !ana_q  : 1'b0;
            meas_n_q <= multi_on ? !meas_q : 1'b0;
        end
    end
    assign analog_done_out_n      = ana_n_q;
    assign measurement_done_out_n = meas_n_q;
    assign measure_start          = start_q;
    assign active_channel         = chan_q;
    assign irq                    = |(ist_q & ien_q);

    // ---------------------------------------------------------------
    // correction storage
    // ---------------------------------------------------------------
    scs_store_if st ();
    logic is_store, is_ref, st_ok;
    assign is_store = wr_acc && paddr == OFS_CMD && cmd[CMD_STORE];
    assign is_ref   = cmd[1:0] == SCS_REF;
    // results store only with multi on; reference entry always allowed
    assign st_ok    = is_store && (multi_on || is_ref);

    assign st.wr_en   = st_ok;
    assign st.wr_kind = cmd[1:0];
    assign st.wr_chan = chan_q;
    assign st.wr_all  = is_ref && ctrl_q[CTRL_REF_COMMON];
    assign st.wr_data = data_q;
    // read port addressed by software alone, independent of the selection
    assign st.rd_chan = rda_q[CH_W+1:2];
    assign st.rd_kind = rda_q[1:0];

    scs_corr_mem u_mem (
        .pclk (pclk),
        .ce   (ce),
        .st   (st)
    );

    // ---------------------------------------------------------------
    // read data
    // ---------------------------------------------------------------
    always_comb begin
        rdat_d = 32'h0000_0000;
        case (paddr)
            OFS_CTRL:     rdat_d = {29'h0, ctrl_q};
            OFS_CHAN:     rdat_d = {24'h0, chan_q};
            OFS_DATA:     rdat_d = data_q;
            OFS_STATUS:   rdat_d = {20'h0, qual_n, scan_chan, meas_q, ana_q, trig_s};
            OFS_IRQ_STAT: rdat_d = {30'h0, ist_q};
            OFS_IRQ_EN:   rdat_d = {30'h0, ien_q};
            OFS_RD_ADDR:  rdat_d = {22'h0, rda_q};
            OFS_RD_DATA:  rdat_d = st.rd_data;
            default:      rdat_d = 32'h0000_0000;
        endcase
    end
    // read data combinational from register state, valid in access phase
    assign prdata = rd_acc ? rdat_d : 32'h0000_0000;
endmodule

// *** scs_sel_sva.sv ***
// concurrent checks on the ports of the scanner channel select block
`timescale 1ns/100ps
module scs_sel_sva (
    input wire logic                    pclk,
    input wire logic                    presetn,
    input wire logic                    ce,
    input wire logic                    psel,
    input wire logic                    penable,
    input wire logic                    pwrite,
    input wire logic [11:0]             paddr,
    input wire logic [31:0]             pwdata,
    input wire logic                    pready,
    input wire logic                    pslverr,
    input wire logic [scs_pkg::CH_W-1:0] channel_number_lines_n,
    input wire logic                    channel_select_qualifier_n,
    input wire logic                    external_trigger_in,
    input wire logic                    analog_done_out_n,
    input wire logic                    measurement_done_out_n,
    input wire logic                    measure_start,
    input wire logic [scs_pkg::CH_W-1:0] active_channel
);
    import scs_pkg::*;
    // ---------------------------------------------------------------
    // shadow of the mode bits, needed because they live in a register
    // ---------------------------------------------------------------
    logic multi_q, multi_d, ext_q, ext_d, apb_wr;
    // next mode values from control writes
    always_comb begin
        apb_wr  = psel && penable && pwrite && ce;
        multi_d = multi_q;
        ext_d   = ext_q;
        if (apb_wr && paddr == OFS_CTRL) begin
            multi_d = pwdata[CTRL_MULTI];
            ext_d   = pwdata[CTRL_EXTERNAL_TRIGGER_IN];
        end
    end
    // register the shadow
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            multi_q <= 1'b0;
            ext_q   <= 1'b0;
        end else begin
            multi_q <= multi_d;
            ext_q   <= ext_d;
        end
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // done outputs forced low; two cycles of slack for the output flop
    a_done_low_off: assert property (!multi_q && !$past(multi_q) && !$past(multi_q, 2)
        |-> !analog_done_out_n && !measurement_done_out_n) else $error("done high, multi off");
    a_start_pulse: assert property (measure_start |=> !measure_start)
        else $error("start longer than one cycle");
    a_start_ext: assert property (measure_start |-> ext_q && $past(external_trigger_in, 2))
        else $error("start without external trigger");
    a_trig_starts: assert property ($rose(external_trigger_in) && ext_q |-> ##[2:4] measure_start)
        else $error("trigger edge not taken");
    a_chan_cause: assert property ($changed(active_channel) |-> measure_start || $past(apb_wr))
        else $error("channel changed without cause");
    a_chan_ignored: assert property (measure_start && !multi_q |-> $stable(active_channel))
        else $error("channel loaded with multi off");
    a_chan_load: assert property (measure_start && multi_q && !channel_select_qualifier_n
        && $past(channel_number_lines_n, 3) == channel_number_lines_n
        |-> active_channel == ~channel_number_lines_n) else $error("channel load wrong");
    a_qual_keeps: assert property (measure_start && channel_select_qualifier_n
        |-> $stable(active_channel)) else $error("loaded while qualifier off");
    a_unmapped_err: assert property (psel && penable && paddr > 12'h024 |-> pslverr)
        else $error("no error on unmapped address");
    a_no_wait: assert property (psel && penable |-> pready) else $error("wait state seen");
endmodule
bind scs_channel_select scs_sel_sva i_scs_sel_sva (.pclk, .presetn, .ce, .psel, .penable,
    .pwrite, .paddr, .pwdata, .pready, .pslverr, .channel_number_lines_n,
    .channel_select_qualifier_n, .external_trigger_in, .analog_done_out_n,
    .measurement_done_out_n, .measure_start, .active_channel);

// *** scs_scanner_model.sv ***
// behavioural scanner driving channel lines, qualifier and trigger
`timescale 1ns/100ps
module scs_scanner_model (
    input  wire logic       pclk,
    output logic [7:0]      channel_number_lines_n,
    output logic            channel_select_qualifier_n,
    output logic            external_trigger_in
);
    // ---------------------------------------------------------------
    // idle levels: unused trigger pin sits at ground
    // ---------------------------------------------------------------
    initial begin
        channel_number_lines_n     = 8'hFF;
        channel_select_qualifier_n = 1'b1;
        external_trigger_in        = 1'b0;
    end
    // channel change: qualifier off, value, qualifier on
    task automatic select(input logic [7:0] ch);
        @(posedge pclk) channel_select_qualifier_n <= 1'b1;
        @(posedge pclk) channel_number_lines_n <= ~ch;
        @(posedge pclk) channel_select_qualifier_n <= 1'b0;
    endtask
    // lines and qualifier set directly, e.g. value shown while qualifier is off
    task automatic present(input logic [7:0] ch, input logic q_n);
        @(posedge pclk) channel_number_lines_n <= ~ch;
        channel_select_qualifier_n <= q_n;
    endtask
    // pulse held long enough for the input synchroniser, then a quiet gap
    task automatic fire();
        @(posedge pclk) external_trigger_in <= 1'b1;
        repeat (3) @(posedge pclk);
        external_trigger_in <= 1'b0;
        repeat (3) @(posedge pclk);
    endtask
endmodule

// *** testbench.sv ***
// self-checking testbench for the scanner channel select block
`timescale 1ns/100ps
module testbench;
    import scs_pkg::*;
    // ---------------------------------------------------------------
    // signals, instances, clock
    // ---------------------------------------------------------------
    logic        pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdv;
    logic [7:0]  channel_number_lines_n, active_channel;
    logic        channel_select_qualifier_n, external_trigger_in, measure_start, irq;
    logic        analog_done_out_n, measurement_done_out_n;
    int          n_fail, cmp_count, n_start, n;
    scs_channel_select i_scs_channel_select (.pclk, .presetn, .ce, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .channel_number_lines_n,
        .channel_select_qualifier_n, .external_trigger_in, .analog_done_out_n,
        .measurement_done_out_n, .measure_start, .active_channel, .irq);
    scs_scanner_model i_scs_scanner_model (.pclk, .channel_number_lines_n,
        .channel_select_qualifier_n, .external_trigger_in);
    // free-running bus clock
    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end
    // count accepted triggers
    always @(posedge pclk) if (measure_start === 1'b1) n_start++;
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_ch(input logic [7:0] e);
        chk({24'h0, active_channel}, {24'h0, e});
    endtask
    // one apb transfer; request held until pready is seen high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk) {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge pclk) penable <= 1'b1;
        @(posedge pclk) while (pready !== 1'b1) @(posedge pclk);
        rdv = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rd_mem(input logic [7:0] ch, input logic [1:0] k, input logic [31:0] e);
        wr(OFS_RD_ADDR, {22'h0, ch, k});
        repeat (2) @(posedge pclk);
        apb(1'b0, OFS_RD_DATA, 32'h0);
        chk(rdv, e);
    endtask
    // ---------------------------------------------------------------
    // scenarios
    // ---------------------------------------------------------------
    task automatic t_reset();
        chk({29'h0, analog_done_out_n, measurement_done_out_n, irq}, 32'h0);
        chk_ch(8'h00);
        apb(1'b0, OFS_CTRL, 32'h0);
        chk(rdv, 32'h0);
        apb(1'b0, 12'h100, 32'h0);
        chk({rdv[30:0], err}, 32'h1);
    endtask
    task automatic t_multi_off();
        wr(OFS_CTRL, 32'h2);
        wr(OFS_CMD, 32'h18);
        i_scs_scanner_model.select(8'h5A);
        n = n_start;
        i_scs_scanner_model.fire();
        chk(32'(n_start - n), 32'h1);
        chk_ch(8'h00);
        chk({30'h0, analog_done_out_n, measurement_done_out_n}, 32'h0);
    endtask
    task automatic t_scan();
        wr(OFS_CTRL, 32'h3);
        i_scs_scanner_model.select(8'h80);
        repeat (4) @(posedge pclk);
        chk_ch(8'h00);
        i_scs_scanner_model.fire();
        chk_ch(8'h80);
        i_scs_scanner_model.select(8'h03);
        i_scs_scanner_model.fire();
        chk_ch(8'h03);
        i_scs_scanner_model.present(8'h44, 1'b1);
        i_scs_scanner_model.fire();
        chk_ch(8'h03);
        apb(1'b0, OFS_STATUS, 32'h0);
        chk(rdv, 32'h0000_0A20);
        apb(1'b0, OFS_IRQ_STAT, 32'h0);
        chk(rdv, 32'h0000_0003);
    endtask
    task automatic t_panel();
        logic [31:0] cmd [4];
        logic [7:0]  ch [4];
        cmd = '{32'h40, 32'h80, 32'h100, 32'h20};
        ch  = '{8'h05, 8'h04, 8'hFA, 8'hFB};
        wr(OFS_CHAN, 32'hFB);
        @(posedge pclk) chk_ch(8'hFB);
        for (int i = 0; i < 4; i++) begin
            wr(OFS_CMD, cmd[i]);
            @(posedge pclk) chk_ch(ch[i]);
        end
        // clock enable low: a panel write must not land
        ce <= 1'b0;
        wr(OFS_CHAN, 32'h11);
        ce <= 1'b1;
        @(posedge pclk) chk_ch(8'hFB);
    endtask
    task automatic t_done();
        wr(OFS_CMD, 32'h8);
        repeat (3) @(posedge pclk);
        chk({30'h0, analog_done_out_n, measurement_done_out_n}, 32'h1);
        wr(OFS_CMD, 32'h10);
        repeat (3) @(posedge pclk);
        chk({30'h0, analog_done_out_n, measurement_done_out_n}, 32'h0);
        i_scs_scanner_model.fire();
        chk({30'h0, analog_done_out_n, measurement_done_out_n}, 32'h3);
        wr(OFS_CTRL, 32'h2);
        repeat (3) @(posedge pclk);
        chk({30'h0, analog_done_out_n, measurement_done_out_n}, 32'h0);
    endtask
    task automatic t_store();
        wr(OFS_CTRL, 32'h1);
        wr(OFS_CHAN, 32'h7);
        wr(OFS_DATA, 32'hA5A50001);
        wr(OFS_CMD, 32'h4);
        wr(OFS_CMD, 32'h6);
        wr(OFS_CTRL, 32'h5);
        wr(OFS_DATA, 32'h0000CAFE);
        wr(OFS_CMD, 32'h7);
        wr(OFS_CTRL, 32'h1);
        wr(OFS_CHAN, 32'h9);
        wr(OFS_DATA, 32'h12345678);
        wr(OFS_CMD, 32'h7);
        @(posedge pclk) presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rd_mem(8'h07, 2'h0, 32'hA5A50001);
        rd_mem(8'h07, 2'h2, 32'hA5A50001);
        rd_mem(8'h09, 2'h3, 32'h12345678);
        rd_mem(8'hFF, 2'h3, 32'h0000CAFE);
        rd_mem(8'h07, 2'h3, 32'h0000CAFE);
    endtask
    task automatic t_irq();
        wr(OFS_IRQ_CLR, 32'h3);
        wr(OFS_IRQ_EN, 32'h1);
        wr(OFS_CTRL, 32'h2);
        i_scs_scanner_model.fire();
        chk({31'h0, irq}, 32'h1);
        apb(1'b0, OFS_IRQ_STAT, 32'h0);
        chk(rdv, 32'h1);
        wr(OFS_IRQ_EN, 32'h0);
        @(posedge pclk) chk({31'h0, irq}, 32'h0);
        wr(OFS_IRQ_EN, 32'h1);
        wr(OFS_IRQ_CLR, 32'h1);
        apb(1'b0, OFS_IRQ_STAT, 32'h0);
        chk({rdv[30:0], irq}, 32'h0);
    endtask
    task automatic report_and_stop();
        $display("comparisons %0d, mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // main sequence; clock enable held high except for the one write in t_panel
    initial begin
        {psel, penable, pwrite, paddr, pwdata, presetn, ce} = {3'b0, 12'h0, 32'h0, 2'b01};
        {n_fail, cmp_count, n_start} = {32'd0, 32'd0, 32'd0};
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_multi_off();
        t_scan();
        t_panel();
        t_done();
        t_store();
        t_irq();
        report_and_stop();
    end
    // watchdog well past the few hundred cycles the run needs
    initial begin
        repeat (20000) @(posedge pclk);
        n_fail++;
        report_and_stop();
    end
endmodule
